// ===== src/flash_wp_pkg.sv
// Types for the flash write-protect and status block
package flash_wp_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} op_state_type;

	typedef enum logic [2:0] {
		PFX_NONE = 3'b001,
		PFX_FIRST = 3'b010,
		PFX_ARMED = 3'b100
	} prefix_state_type;

endpackage

// ===== src/flash_wp_regs.svh
// Constants for the flash write-protect and status block
`ifndef FLASH_WP_REGS_SVH
`define FLASH_WP_REGS_SVH

// Instruction codes (unlock and prefix codes fixed, the rest plain defaults)
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE 8'hC7
`define OP_WRITE_SR1 8'h01
`define OP_WRITE_SR2 8'h31
`define OP_WRITE_SR3 8'h11
`define OP_READ_SR1 8'h05
`define OP_READ_SR2 8'h35
`define OP_READ_SR3 8'h15
`define OP_SUSPEND 8'h75
`define OP_POWER_DOWN 8'hB9
`define OP_RELEASE_PD 8'hAB
`define OP_BLOCK_UNLOCK 8'h39
`define OP_SECURITY_PROGRAM 8'h42
`define OP_SECURITY_ERASE 8'h44
`define OP_PREFIX_FIRST 8'hAA
`define OP_PREFIX_SECOND 8'h55

// Status bit positions: low word holds S7..S0, mid word S15..S8
`define SR_BUSY 0
`define SR_LATCH 1
`define SR_RANGE_LO 2
`define SR_RANGE_HI 4
`define SR_TOP_BOTTOM 5
`define SR_SMALL_UNIT 6
`define SR_GUARD 7
`define SR_LOCKDOWN 0
`define SR_INVERT 6
`define SR_SCHEME 2

// Reset values and writable masks
`define SR_LOW_RST 8'h00
`define SR_MID_RST 8'h00
`define SR_LOW_WMASK 8'hFC
`define SR_MID_WMASK 8'h41

// Array geometry
`define LOCK_BITS 92
`define LOCK_SECTORS 32
`define LAST_BLOCK 6'h3D
`define ARRAY_LAST 22'h3D_FFFF

// Timing
`define CLK_PERIOD_NS 50
`define PUW_TIME_US 10
`define PUW_CYCLES ((`PUW_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TW_TIME_NS 1000
`define TW_CYCLES ((`TW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TPP_TIME_NS 2000
`define TPP_CYCLES ((`TPP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TSE_TIME_NS 4000
`define TSE_CYCLES ((`TSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/flash_write_protect_status.sv
// Write-protect, lock-bit and status-register control of the serial flash
`timescale 1ns/1ps
`include "flash_wp_regs.svh"

module flash_write_protect_status (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// Decoded instruction from the serial front end
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_op,
	input wire logic [21:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	// Pin and mode
	input wire logic wp_n,
	input wire logic quad_mode,
	// Status words and state
	output logic [7:0] status_word_low,
	output logic [7:0] status_word_mid,
	output logic lock_scheme_select,
	output logic power_down,
	// Instruction outcome pulses
	output logic cmd_accept,
	output logic cmd_refuse,
	output logic array_start
);

	flash_wp_pkg::op_state_type state_q;
	flash_wp_pkg::prefix_state_type pfx_q;
	logic [11:0] cnt_q;
	logic [11:0] pu_cnt_q;
	logic [7:0] sr_low_q;
	logic [7:0] sr_mid_q;
	logic scheme_q;
	logic otp_q;
	logic pd_q;
	logic [`LOCK_BITS-1:0] lock_q;
	logic [1:0] pend_sel_q;
	logic [7:0] pend_data_q;
	logic pend_otp_q;
	logic accept_q;
	logic refuse_q;
	logic start_q;

	logic is_we, is_wd, is_pp, is_se, is_be, is_ce;
	logic is_wsr1, is_wsr2, is_wsr3, is_wsr, is_rsr, is_sus;
	logic is_pd, is_rpd, is_unlock, is_secp, is_sece, is_aa, is_55;
	logic is_array, is_security_op;
	logic we_latch, busy, pu_hold, guard, lockdown, pin_block;
	logic [21:0] reg_lo, reg_hi;
	logic range_lo, range_hi, lock_hit, array_prot;
	logic wsr_ok, take, accept_go, refuse_go, start_op, idle_go, done;
	logic [6:0] unlock_idx;
	logic [11:0] op_cycles;

	assign is_we = cmd_op == `OP_WRITE_ENABLE;
	assign is_wd = cmd_op == `OP_WRITE_DISABLE;
	assign is_pp = cmd_op == `OP_PAGE_PROGRAM;
	assign is_se = cmd_op == `OP_SECTOR_ERASE;
	assign is_be = cmd_op == `OP_BLOCK_ERASE;
	assign is_ce = cmd_op == `OP_CHIP_ERASE;
	assign is_wsr1 = cmd_op == `OP_WRITE_SR1;
	assign is_wsr2 = cmd_op == `OP_WRITE_SR2;
	assign is_wsr3 = cmd_op == `OP_WRITE_SR3;
	assign is_wsr = is_wsr1 | is_wsr2 | is_wsr3;
	assign is_rsr = (cmd_op == `OP_READ_SR1) | (cmd_op == `OP_READ_SR2) | (cmd_op == `OP_READ_SR3);
	assign is_sus = cmd_op == `OP_SUSPEND;
	assign is_pd = cmd_op == `OP_POWER_DOWN;
	assign is_rpd = cmd_op == `OP_RELEASE_PD;
	assign is_unlock = cmd_op == `OP_BLOCK_UNLOCK;
	assign is_secp = cmd_op == `OP_SECURITY_PROGRAM;
	assign is_sece = cmd_op == `OP_SECURITY_ERASE;
	assign is_aa = cmd_op == `OP_PREFIX_FIRST;
	assign is_55 = cmd_op == `OP_PREFIX_SECOND;
	assign is_array = is_pp | is_se | is_be | is_ce;
	assign is_security_op = is_secp | is_sece;

	assign we_latch = sr_low_q[`SR_LATCH];
	assign busy = sr_low_q[`SR_BUSY];
	assign guard = sr_low_q[`SR_GUARD];
	assign lockdown = sr_mid_q[`SR_LOCKDOWN];
	assign pu_hold = pu_cnt_q != 12'h000;
	assign done = (state_q == flash_wp_pkg::ST_BUSY) && (cnt_q == 12'h000);

	// Lock bit index: bottom sectors 0..15, top sectors 16..31, then middle blocks
	function automatic logic [6:0] lock_idx_f(input logic [21:0] a);
		logic [5:0] blk;
		blk = a[21:16];
		if (blk == 6'h00)
			return {3'h0, a[15:12]};
		else if (blk == `LAST_BLOCK)
			return {3'h1, a[15:12]};
		else
			return 7'(blk) + 7'h1F;
	endfunction

	// Beyond the array counts as locked
	function automatic logic lock_hit_f(input logic [`LOCK_BITS-1:0] lk, input logic [21:0] a,
		input logic blk_scope, input logic chip);
		logic [6:0] idx;
		idx = lock_idx_f(a);
		if (chip)
			return |lk;
		else if (blk_scope && a[21:16] == 6'h00)
			return |lk[15:0];
		else if (blk_scope && a[21:16] == `LAST_BLOCK)
			return |lk[`LOCK_SECTORS-1:16];
		else if (idx >= 7'(`LOCK_BITS))
			return 1'b1;
		else
			return lk[idx];
	endfunction

	// Range protection is one span at an array end, so checking both ends of the target suffices
	always_comb begin
		reg_lo = cmd_addr;
		reg_hi = cmd_addr;
		if (is_pp) begin
			reg_lo = {cmd_addr[21:8], 8'h00};
			reg_hi = {cmd_addr[21:8], 8'hFF};
		end else if (is_se) begin
			reg_lo = {cmd_addr[21:12], 12'h000};
			reg_hi = {cmd_addr[21:12], 12'hFFF};
		end else if (is_be) begin
			reg_lo = {cmd_addr[21:16], 16'h0000};
			reg_hi = {cmd_addr[21:16], 16'hFFFF};
		end else if (is_ce) begin
			reg_lo = 22'h00_0000;
			reg_hi = `ARRAY_LAST;
		end
	end

	range_decode u_range_lo (
		.range_bits(sr_low_q[`SR_RANGE_HI:`SR_RANGE_LO]),
		.top_bottom_select(sr_low_q[`SR_TOP_BOTTOM]),
		.small_unit_select(sr_low_q[`SR_SMALL_UNIT]),
		.invert_protection(sr_mid_q[`SR_INVERT]),
		.addr(reg_lo),
		.hit(range_lo)
	);

	range_decode u_range_hi (
		.range_bits(sr_low_q[`SR_RANGE_HI:`SR_RANGE_LO]),
		.top_bottom_select(sr_low_q[`SR_TOP_BOTTOM]),
		.small_unit_select(sr_low_q[`SR_SMALL_UNIT]),
		.invert_protection(sr_mid_q[`SR_INVERT]),
		.addr(reg_hi),
		.hit(range_hi)
	);

	assign lock_hit = lock_hit_f(lock_q, cmd_addr, is_be, is_ce);
	assign array_prot = scheme_q ? lock_hit : (range_lo | range_hi);
	assign unlock_idx = lock_idx_f(cmd_addr);

	// Lockdown and the permanent flag beat everything; the pin counts only outside quad modes
	assign pin_block = guard & !wp_n & !quad_mode;
	assign wsr_ok = we_latch & !otp_q & !lockdown & !pin_block;

	always_comb begin
		take = 1'b0;
		if (pd_q)
			take = is_rpd;
		else if (busy)
			take = is_rsr | is_sus;
		else if (is_we)
			take = !pu_hold;
		else if (is_array)
			take = we_latch & !pu_hold & !array_prot;
		else if (is_security_op)
			take = we_latch & !pu_hold;
		else if (is_wsr)
			take = !pu_hold & wsr_ok;
		else
			take = 1'b1;
	end

	assign accept_go = cmd_valid & take;
	assign refuse_go = cmd_valid & !take;
	assign idle_go = accept_go & !pd_q & !busy;
	assign start_op = idle_go & (is_array | is_security_op | is_wsr);

	always_comb begin
		if (is_wsr)
			op_cycles = 12'(`TW_CYCLES - 1);
		else if (is_pp | is_secp)
			op_cycles = 12'(`TPP_CYCLES - 1);
		else
			op_cycles = 12'(`TSE_CYCLES - 1);
	end

	// Write-inhibit window after power-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pu_cnt_q <= 12'(`PUW_CYCLES);
		else if (pu_hold)
			pu_cnt_q <= pu_cnt_q - 12'h001;
	end

	// Operation sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= flash_wp_pkg::ST_IDLE;
			cnt_q <= 12'h000;
		end else begin
			unique case (state_q)
				flash_wp_pkg::ST_IDLE: begin
					if (start_op) begin
						state_q <= flash_wp_pkg::ST_BUSY;
						cnt_q <= op_cycles;
					end
				end
				flash_wp_pkg::ST_BUSY: begin
					if (cnt_q == 12'h000)
						state_q <= flash_wp_pkg::ST_IDLE;
					else
						cnt_q <= cnt_q - 12'h001;
				end
			endcase
		end
	end

	// Status write held until the operation completes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_sel_q <= 2'h0;
			pend_data_q <= 8'h00;
			pend_otp_q <= 1'b0;
		end else if (start_op) begin
			pend_sel_q <= is_wsr1 ? 2'h1 : is_wsr2 ? 2'h2 : is_wsr3 ? 2'h3 : 2'h0;
			pend_data_q <= cmd_data;
			pend_otp_q <= pfx_q == flash_wp_pkg::PFX_ARMED;
		end else if (done) begin
			pend_sel_q <= 2'h0;
		end
	end

	// Low status word: busy, latch, range and guard bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_low_q <= `SR_LOW_RST;
		end else if (done) begin
			if (pend_sel_q == 2'h1)
				sr_low_q <= (sr_low_q & ~`SR_LOW_WMASK) | (pend_data_q & `SR_LOW_WMASK);
			sr_low_q[`SR_BUSY] <= 1'b0;
			sr_low_q[`SR_LATCH] <= 1'b0;
		end else if (start_op) begin
			sr_low_q[`SR_BUSY] <= 1'b1;
		end else if (idle_go && is_we) begin
			sr_low_q[`SR_LATCH] <= 1'b1;
		end else if (idle_go && is_wd) begin
			sr_low_q[`SR_LATCH] <= 1'b0;
		end
	end

	// Mid status word: lockdown and complement bits; lockdown clears only on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sr_mid_q <= `SR_MID_RST;
		else if (done && pend_sel_q == 2'h2)
			sr_mid_q <= (sr_mid_q & ~`SR_MID_WMASK) | (pend_data_q & `SR_MID_WMASK);
	end

	// Permanent protection; held in flops, so a reset here stands for a fresh part
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			otp_q <= 1'b0;
		else if (done && pend_sel_q == 2'h2 && pend_otp_q && pend_data_q[`SR_LOCKDOWN])
			otp_q <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			scheme_q <= 1'b0;
		else if (done && pend_sel_q == 2'h3)
			scheme_q <= pend_data_q[`SR_SCHEME];
	end

	// Prefix tracker: any other instruction breaks the sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pfx_q <= flash_wp_pkg::PFX_NONE;
		else if (cmd_valid) begin
			if (idle_go && is_aa)
				pfx_q <= flash_wp_pkg::PFX_FIRST;
			else if (idle_go && is_55 && pfx_q == flash_wp_pkg::PFX_FIRST)
				pfx_q <= flash_wp_pkg::PFX_ARMED;
			else
				pfx_q <= flash_wp_pkg::PFX_NONE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pd_q <= 1'b0;
		else if (accept_go && pd_q && is_rpd)
			pd_q <= 1'b0;
		else if (idle_go && is_pd)
			pd_q <= 1'b1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `LOCK_BITS; gi++) begin : g_lock
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					lock_q[gi] <= 1'b1;
				else if (idle_go && is_unlock && unlock_idx == 7'(gi))
					lock_q[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accept_q <= 1'b0;
			refuse_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			accept_q <= accept_go;
			refuse_q <= refuse_go;
			start_q <= start_op & is_array;
		end
	end

	assign status_word_low = sr_low_q;
	assign status_word_mid = sr_mid_q;
	assign lock_scheme_select = scheme_q;
	assign power_down = pd_q;
	assign cmd_accept = accept_q;
	assign cmd_refuse = refuse_q;
	assign array_start = start_q;

	latch_reset_a: assert property (@(posedge clk) $fell(rst) |-> !status_word_low[`SR_LATCH] && !status_word_low[`SR_BUSY])
		else $error("Latch or busy set after reset");

	latch_needed_a: assert property (@(posedge clk) disable iff (rst)
		cmd_valid && is_array && !we_latch && !busy && !pd_q |=> cmd_refuse && !array_start)
		else $error("Array op taken without write enable");

	latch_set_a: assert property (@(posedge clk) disable iff (rst)
		cmd_valid && is_we && !busy && !pd_q && !pu_hold |=> status_word_low[`SR_LATCH] && cmd_accept)
		else $error("Write enable did not set the latch");

	op_finish_a: assert property (@(posedge clk) disable iff (rst)
		start_op && is_wsr |=> busy [*8] ##[1:30] (!status_word_low[`SR_BUSY] && !status_word_low[`SR_LATCH]))
		else $error("Status write did not finish and clear latch in time");

	powerup_block_a: assert property (@(posedge clk) disable iff (rst)
		pu_hold && cmd_valid && (is_we || is_wsr) && !pd_q |=> cmd_refuse)
		else $error("Write instruction taken during power-up delay");

	pd_ignore_a: assert property (@(posedge clk) disable iff (rst)
		pd_q && cmd_valid && !is_rpd |=> cmd_refuse && power_down && $stable(status_word_low))
		else $error("Instruction obeyed in power-down");

	lock_reset_a: assert property (@(posedge clk) $fell(rst) |-> &lock_q)
		else $error("Lock bits not all set after reset");

	busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
		busy && !pd_q && cmd_valid && !(is_rsr || is_sus) |=> cmd_refuse)
		else $error("Instruction taken while busy");

	lockdown_a: assert property (@(posedge clk) disable iff (rst)
		lockdown && cmd_valid && is_wsr |=> cmd_refuse ##1 $stable(status_word_mid))
		else $error("Status write taken under lockdown");

	wp_gate_a: assert property (@(posedge clk) disable iff (rst)
		guard && !lockdown && !wp_n && !quad_mode && cmd_valid && is_wsr |=> cmd_refuse && !busy)
		else $error("Status write passed a low protect pin");

	lock_scheme_a: assert property (@(posedge clk) disable iff (rst)
		scheme_q && lock_hit && cmd_valid && is_array |=> cmd_refuse && !array_start)
		else $error("Locked area was programmed or erased");

endmodule // flash_write_protect_status

// ===== src/range_decode.sv
// Range-bit protection decode for one address
`timescale 1ns/1ps
`include "flash_wp_regs.svh"

module range_decode (
	// Protection fields
	input wire logic [2:0] range_bits,
	input wire logic top_bottom_select,
	input wire logic small_unit_select,
	input wire logic invert_protection,
	// Address under test
	input wire logic [21:0] addr,
	output logic hit
);

	logic [22:0] size;
	logic [21:0] off;
	logic all_prot;
	logic raw;

	always_comb begin
		all_prot = range_bits[2] & range_bits[1];
		size = 23'h00_0000;
		if (range_bits != 3'h0) begin
			if (!small_unit_select)
				size = 23'h01_0000 << 3'(range_bits - 3'h1);
			else if (range_bits[2])
				size = 23'h00_8000;
			else
				size = 23'h00_1000 << 3'(range_bits - 3'h1);
		end
		off = top_bottom_select ? addr : 22'(`ARRAY_LAST - addr);
		raw = all_prot | ({1'b0, off} < size);
		hit = raw ^ invert_protection;
	end

endmodule // range_decode

// ===== tb/flash_host_model.sv
// Host model presenting decoded flash instructions to the block
`timescale 1ns/1ps

module flash_host_model (
	// Clock
	input wire logic clk,
	// Instruction to the device
	output logic cmd_valid,
	output logic [7:0] cmd_op,
	output logic [21:0] cmd_addr,
	output logic [7:0] cmd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_addr = 22'h00_0000;
		cmd_data = 8'h00;
	end

	// Lines flip once released so a stale code never reads as a fresh one
	task automatic send(input logic [7:0] op, input logic [21:0] addr, input logic [7:0] data);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= addr;
		cmd_data <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_op <= ~op;
		cmd_addr <= ~addr;
		cmd_data <= ~data;
	endtask
endmodule // flash_host_model

// ===== tb/flash_write_protect_status_tb.sv
// Self-checking bench for the flash write-protect and status block
`timescale 1ns/1ps
`include "flash_wp_regs.svh"

`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; $display("Error %s expected %0h seen %0h", name, exp, got); end end

module flash_write_protect_status_tb;
	localparam logic [2:0] ACC = 3'h4;
	localparam logic [2:0] REF = 3'h2;
	localparam logic [2:0] ARR = 3'h5;
	// Status low, status mid, erase address, erase expected to run
	localparam logic [38:0] TBL [10] = '{
		{8'h1C, 8'h00, 22'h12_3456, 1'b0}, {8'h04, 8'h00, 22'h3D_0000, 1'b0},
		{8'h04, 8'h00, 22'h3C_0000, 1'b1}, {8'h24, 8'h00, 22'h00_0000, 1'b0},
		{8'h24, 8'h00, 22'h3D_0000, 1'b1}, {8'h44, 8'h00, 22'h3D_F000, 1'b0},
		{8'h44, 8'h00, 22'h3D_E000, 1'b1}, {8'h04, 8'h40, 22'h3D_0000, 1'b1},
		{8'h04, 8'h40, 22'h00_0000, 1'b0}, {8'h00, 8'h00, 22'h20_0000, 1'b1}};

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b0;
	logic quad_mode = 1'b0;
	logic cmd_valid;
	logic [7:0] cmd_op;
	logic [21:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [7:0] status_word_low;
	logic [7:0] status_word_mid;
	logic lock_scheme_select;
	logic power_down;
	logic cmd_accept;
	logic cmd_refuse;
	logic array_start;
	int bad_count = 0;
	int check_count = 0;
	logic [2:0] exp_q[$];
	logic [31:0] seed = 32'hd4c3_741b;

	always #25 clk = ~clk;

	flash_host_model flash_host_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data));

	flash_write_protect_status flash_write_protect_status_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .wp_n(wp_n), .quad_mode(quad_mode),
		.status_word_low(status_word_low), .status_word_mid(status_word_mid),
		.lock_scheme_select(lock_scheme_select), .power_down(power_down), .cmd_accept(cmd_accept),
		.cmd_refuse(cmd_refuse), .array_start(array_start));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Every instruction yields one outcome pulse, oldest note first; looked at mid-cycle where it stands
	always @(negedge clk) begin
		logic [2:0] want;
		if (cmd_accept === 1'b1 || cmd_refuse === 1'b1) begin
			want = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h0;
			`CHK("outcome", want, {cmd_accept, cmd_refuse, array_start})
		end
	end

	task automatic cmd(input logic [7:0] op, input logic [21:0] addr, input logic [7:0] data, input logic [2:0] exp);
		exp_q.push_back(exp);
		flash_host_model_inst.send(op, addr, data);
	endtask

	// Let the taking edge and the next one land before looking
	task automatic look();
		@(posedge clk);
		#1;
	endtask

	task automatic idle();
		int n;
		n = 0;
		look();
		while (status_word_low[`SR_BUSY] !== 1'b0 && n < 200) begin
			look();
			n++;
		end
		`CHK("busy_clear", 1'b0, status_word_low[`SR_BUSY])
	endtask

	task automatic wrsr(input logic [7:0] op, input logic [7:0] data);
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(op, 22'h00_0000, data, ACC);
		idle();
	endtask

	task automatic erase(input logic [21:0] addr, input logic ok);
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_SECTOR_ERASE, addr, 8'h00, ok ? ARR : REF);
		if (ok) begin
			idle();
		end
	endtask

	task automatic power_up();
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		look();
		`CHK("low_reset", 8'h00, status_word_low)
		`CHK("mid_reset", 8'h00, status_word_mid)
		`CHK("scheme_reset", 1'b0, lock_scheme_select)
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, REF);
		cmd(`OP_READ_SR1, 22'h00_0000, 8'h00, ACC);
		repeat (200) @(posedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] d;
		power_up();
		cmd(`OP_WRITE_SR1, 22'h00_0000, 8'h1C, REF);
		look();
		`CHK("refused_write", 8'h00, status_word_low)
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		look();
		`CHK("latch_set", 1'b1, status_word_low[`SR_LATCH])
		cmd(`OP_WRITE_DISABLE, 22'h00_0000, 8'h00, ACC);
		look();
		`CHK("latch_clear", 1'b0, status_word_low[`SR_LATCH])
		cmd(`OP_SECTOR_ERASE, 22'h20_0000, 8'h00, REF);
		repeat (3) begin
			r = rnd();
			d = r[7:0] & 8'h7C;
			cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
			cmd(`OP_WRITE_SR1, 22'h00_0000, d, ACC);
			look();
			`CHK("busy_set", 1'b1, status_word_low[`SR_BUSY])
			cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, REF);
			cmd(`OP_READ_SR1, 22'h00_0000, 8'h00, ACC);
			idle();
			`CHK("status_low", d, status_word_low)
		end
		foreach (TBL[i]) begin
			wrsr(`OP_WRITE_SR1, TBL[i][38:31]);
			wrsr(`OP_WRITE_SR2, TBL[i][30:23]);
			erase(TBL[i][22:1], TBL[i][0]);
		end
		wrsr(`OP_WRITE_SR3, 8'h04);
		`CHK("scheme_set", 1'b1, lock_scheme_select)
		erase(22'h10_0000, 1'b0);
		cmd(`OP_BLOCK_UNLOCK, 22'h10_0000, 8'h00, ACC);
		erase(22'h10_0000, 1'b1);
		erase(22'h11_0000, 1'b0);
		cmd(`OP_BLOCK_UNLOCK, 22'h00_1000, 8'h00, ACC);
		erase(22'h00_1000, 1'b1);
		erase(22'h00_2000, 1'b0);
		cmd(`OP_BLOCK_ERASE, 22'h00_0000, 8'h00, REF);
		cmd(`OP_CHIP_ERASE, 22'h00_0000, 8'h00, REF);
		cmd(`OP_PAGE_PROGRAM, 22'h10_0100, 8'h00, ARR);
		cmd(`OP_SUSPEND, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_READ_SR2, 22'h00_0000, 8'h00, ACC);
		idle();
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_SECURITY_PROGRAM, 22'h00_0000, 8'h00, ACC);
		look();
		`CHK("security_busy", 1'b1, status_word_low[`SR_BUSY])
		idle();
		`CHK("security_done", 8'h00, status_word_low)
		wrsr(`OP_WRITE_SR3, 8'h00);
		wrsr(`OP_WRITE_SR1, 8'h80);
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_WRITE_SR1, 22'h00_0000, 8'h00, REF);
		look();
		`CHK("guarded_low", 8'h82, status_word_low)
		@(posedge clk) quad_mode <= 1'b1;
		wrsr(`OP_WRITE_SR1, 8'h80);
		@(posedge clk) quad_mode <= 1'b0;
		wp_n <= 1'b1;
		wrsr(`OP_WRITE_SR1, 8'h00);
		`CHK("guard_released", 8'h00, status_word_low)
		@(posedge clk) wp_n <= 1'b0;
		wrsr(`OP_WRITE_SR2, 8'h01);
		`CHK("lockdown_set", 8'h01, status_word_mid)
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_WRITE_SR1, 22'h00_0000, 8'h1C, REF);
		look();
		`CHK("locked_low", 8'h02, status_word_low)
		power_up();
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_PREFIX_FIRST, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_PREFIX_SECOND, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_WRITE_SR2, 22'h00_0000, 8'h01, ACC);
		idle();
		cmd(`OP_WRITE_ENABLE, 22'h00_0000, 8'h00, ACC);
		cmd(`OP_WRITE_SR2, 22'h00_0000, 8'h00, REF);
		cmd(`OP_POWER_DOWN, 22'h00_0000, 8'h00, ACC);
		look();
		`CHK("pd_entered", 1'b1, power_down)
		cmd(`OP_WRITE_DISABLE, 22'h00_0000, 8'h00, REF);
		cmd(`OP_RELEASE_PD, 22'h00_0000, 8'h00, ACC);
		look();
		`CHK("pd_left", 1'b0, power_down)
		repeat (4) @(posedge clk);
		`CHK("outcomes_all_seen", 1'b1, exp_q.size() == 0)
		report_and_stop();
	end
endmodule // flash_write_protect_status_tb
